// File: pkg/pmx_pkg.sv
// Shared constants and carrier types for the port C to E alternate-function mux
package pmx_pkg;

  // Subregister indices written through the per-port address register
  localparam logic [7:0] PMX_SUB_NONE = 8'h00;
  localparam logic [7:0] PMX_SUB_AF   = 8'h02;
  localparam logic [7:0] PMX_SUB_FS1  = 8'h07;
  localparam logic [7:0] PMX_SUB_FS2  = 8'h08;

  // Port selector codes for the configuration port
  localparam logic [1:0] PMX_PORT_C = 2'h0;
  localparam logic [1:0] PMX_PORT_D = 2'h1;
  localparam logic [1:0] PMX_PORT_E = 2'h2;

  // Reset values
  localparam logic [7:0] PMX_ADDR_RST = 8'h00;
  localparam logic [7:0] PMX_AF_RST   = 8'h00;
  localparam logic [7:0] PMX_AFS_RST  = 8'h00;

  // Pin positions with a fixed role
  localparam int PMX_C_SS   = 2;
  localparam int PMX_C_CMP0 = 3;
  localparam int PMX_C_MOSI = 4;
  localparam int PMX_C_SCK  = 5;
  localparam int PMX_C_T2IO = 6;
  localparam int PMX_C_T2   = 7;
  localparam int PMX_D_CTS  = 3;
  localparam int PMX_D_RX   = 4;
  localparam int PMX_D_TX   = 5;
  localparam int PMX_D_DE   = 6;
  localparam int PMX_D_CMP0 = 7;
  localparam int PMX_E_TIMER_FOUR_INPUT = 0;
  localparam int PMX_E_SCL  = 1;
  localparam int PMX_E_SDA  = 2;
  localparam int PMX_E_T4CH = 3;

  // Edge detector pin count and package build code
  localparam int         PMX_IRQ_PINS  = 24;
  localparam logic [0:0] PMX_PKG_LARGE = 1'h1;

  // Output value and enable for the eight pins of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pmx_pin_drv_t;

  // Signals that peripherals present toward the pins
  typedef struct packed {
    logic       spi_ss_out;
    logic       spi_ss_oe;
    logic       spi_mosi_out;
    logic       spi_mosi_oe;
    logic       spi_sck_out;
    logic       spi_sck_oe;
    logic       timer_two_output;
    logic       timer_two_oe;
    logic       comparator0_result_output;
    logic       comparator1_result_output;
    logic       comparator1_oe;
    logic       uart_b_transmit;
    logic       uart_b_driver_enable;
    logic       i2c_scl_low;
    logic       i2c_sda_low;
    logic [3:0] timer_four_ch_out;
    logic [3:0] timer_four_ch_oe;
  } pmx_periph_out_t;

  // Pin levels handed to peripherals
  typedef struct packed {
    logic       spi_ss_in;
    logic       spi_mosi_in;
    logic       spi_sck_in;
    logic       timer_two_input;
    logic       uart_b_clear_to_send;
    logic       uart_b_receive;
    logic       i2c_scl_in;
    logic       i2c_sda_in;
    logic       timer_four_input;
    logic [3:0] timer_four_ch_in;
  } pmx_periph_in_t;

  // Idle levels when a function is not routed: SPI select, UART and I2C lines high, others low
  localparam pmx_periph_in_t PMX_PERIPH_IN_IDLE = '{
    spi_ss_in: 1'h1, spi_mosi_in: 1'h0, spi_sck_in: 1'h0, timer_two_input: 1'h0,
    uart_b_clear_to_send: 1'h1, uart_b_receive: 1'h1, i2c_scl_in: 1'h1,
    i2c_sda_in: 1'h1, timer_four_input: 1'h0, timer_four_ch_in: 4'h0};

  // Analog switch closures
  typedef struct packed {
    logic analog_channel_four;
    logic analog_channel_five;
    logic analog_channel_six;
    logic comparator0_positive_input;
    logic comparator0_negative_input;
    logic comparator1_negative_input;
    logic comparator1_positive_input;
  } pmx_analog_t;

endpackage

// File: rtl/pmx_edge_det.sv
// Pin synchroniser and per-pin edge detector for interrupt requests
`timescale 1ns/1ps
module pmx_edge_det
  import pmx_pkg::*;
#(
  parameter int WIDTH = PMX_IRQ_PINS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_async,
  input  wire logic [WIDTH-1:0] any_edge,
  input  wire logic [WIDTH-1:0] rising,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] pulse_r;
  logic [WIDTH-1:0] pulse_nxt;

  // Elaboration check: at least one pin
  if (WIDTH < 1) begin : g_bad_width
    $error("pmx_edge_det: WIDTH must be at least 1");
  end

  // Edge qualification per pin, one-cycle pulse per edge
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_comb begin
        if (any_edge[g]) begin
          pulse_nxt[g] = sync_r[g] ^ prev_r[g]; // RL13
        end else if (rising[g]) begin
          pulse_nxt[g] = sync_r[g] & ~prev_r[g]; // RL12
        end else begin
          pulse_nxt[g] = ~sync_r[g] & prev_r[g]; // RL12
        end
      end
    end
  endgenerate

  // Two-stage sync; meta_r feeds only sync_r
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r  <= '0;
      sync_r  <= '0;
      prev_r  <= '0;
      pulse_r <= '0;
    end else if (ce) begin
      meta_r  <= pin_async;
      sync_r  <= meta_r;
      prev_r  <= sync_r;
      pulse_r <= pulse_nxt; // RL16
    end
  end

  assign pin_sync   = sync_r;
  assign edge_pulse = pulse_r;

endmodule

// File: rtl/pmx_port_mux.sv
// Alternate-function mux for ports C, D and E with pin edge interrupts
// Notes on behaviour
// [RL1] PC0: clear select none, set analog/LED
// [RL2] PC1: clear select none, set analog/LED
// [RL3] PC2: clear select SPI select, set analog/LED
// [RL4] PC4/PC5: SPI data/clock, else LED drive
// [RL5] PC6/PC7: timer two functions, else LED
// [RL6] Second select register stored, never steers pins
// [RL7] Function drives pin only when enable set
// [RL8] Ports D/E: enable alone connects function
// [RL9] Timer four functions only in large build
// [RL10] PD3 carries clear-to-send and comparator one
// [RL11] PD4-PD6: UART B receive, transmit, enable
// [RL12] Some pins interrupt on chosen single edge
// [RL13] Other pins interrupt on both edges
// [RL14] Subregisters reached via address then control
// [RL15] Enable clear: pin is plain GPIO
// [RL16] Synchronous sampling, one-cycle request per edge
`timescale 1ns/1ps
module pmx_port_mux
  import pmx_pkg::*;
#(
  parameter logic [0:0] LARGE_PKG = PMX_PKG_LARGE
) (
  input  wire logic                    CLK,
  input  wire logic                    RSTN,
  input  wire logic                    CE,
  input  wire logic [7:0]              PIN_C_IN,
  input  wire logic [7:0]              PIN_D_IN,
  input  wire logic [7:0]              PIN_E_IN,
  input  wire pmx_pin_drv_t            GPIO_C,
  input  wire pmx_pin_drv_t            GPIO_D,
  input  wire pmx_pin_drv_t            GPIO_E,
  input  wire pmx_periph_out_t         PERIPH_OUT,
  input  wire logic [1:0]              SUB_PORT_SEL,
  input  wire logic                    ADDR_WE,
  input  wire logic [7:0]              ADDR_WDATA,
  input  wire logic                    CTL_WE,
  input  wire logic [7:0]              CTL_WDATA,
  input  wire logic [PMX_IRQ_PINS-1:0] IRQ_ANY_EDGE,
  input  wire logic [PMX_IRQ_PINS-1:0] IRQ_RISING,
  output pmx_pin_drv_t                 PIN_C_DRV,
  output pmx_pin_drv_t                 PIN_D_DRV,
  output pmx_pin_drv_t                 PIN_E_DRV,
  output pmx_periph_in_t               PERIPH_IN,
  output pmx_analog_t                  ANALOG_SEL,
  output logic [7:0]                   LED_DRIVE_EN,
  output logic [7:0]                   CTL_RDATA,
  output logic [PMX_IRQ_PINS-1:0]      IRQ_REQ
);

  // Does the address value select the given subregister
  function automatic logic sub_hit(input logic [7:0] addr, input logic [7:0] idx);
    sub_hit = (addr == idx);
  endfunction

  logic [7:0]      addr_r [3];
  logic [7:0]      addr_nxt [3];
  logic [7:0]      af_r [3];
  logic [7:0]      af_nxt [3];
  logic [7:0]      fs1_r;
  logic [7:0]      fs1_nxt;
  logic [7:0]      fs2_r;
  logic [7:0]      fs2_nxt;
  logic [7:0]      rdata_r;
  logic [7:0]      rdata_nxt;
  logic [7:0]      cur_addr;
  logic [7:0]      wr_addr;
  logic [1:0]      port_idx;
  logic            port_ok;
  logic [23:0]     pin_s;
  logic [23:0]     irq_w;
  logic [7:0]      c_s;
  logic [7:0]      d_s;
  logic [7:0]      e_s;
  logic            t4_ok;
  pmx_pin_drv_t    c_drv_r;
  pmx_pin_drv_t    c_drv_nxt;
  pmx_pin_drv_t    d_drv_r;
  pmx_pin_drv_t    d_drv_nxt;
  pmx_pin_drv_t    e_drv_r;
  pmx_pin_drv_t    e_drv_nxt;
  pmx_periph_in_t  pin_r;
  pmx_periph_in_t  pin_nxt;
  pmx_analog_t     ana_r;
  pmx_analog_t     ana_nxt;
  logic [7:0]      led_r;
  logic [7:0]      led_nxt;

  // Pins C, D, E stacked low to high; sync and edges live in one place
  pmx_edge_det #(
    .WIDTH (PMX_IRQ_PINS)
  ) u_edge (
    .clk        (CLK),
    .rst_n      (RSTN),
    .ce         (CE),
    .pin_async  ({PIN_E_IN, PIN_D_IN, PIN_C_IN}),
    .any_edge   (IRQ_ANY_EDGE),
    .rising     (IRQ_RISING),
    .pin_sync   (pin_s),
    .edge_pulse (irq_w)
  );

  assign c_s   = pin_s[7:0];
  assign d_s   = pin_s[15:8];
  assign e_s   = pin_s[23:16];
  assign t4_ok = (LARGE_PKG == PMX_PKG_LARGE);

  // Configuration port decode; selector 3 reaches nothing
  assign port_ok  = (SUB_PORT_SEL != 2'h3);
  assign port_idx = port_ok ? SUB_PORT_SEL : PMX_PORT_C;
  assign cur_addr = addr_r[port_idx];
  assign wr_addr  = port_ok ? cur_addr : PMX_SUB_NONE;

  // Subregister next values; a same-cycle address write takes effect after
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      addr_nxt[p] = addr_r[p];
      af_nxt[p]   = af_r[p];
    end
    fs1_nxt = fs1_r;
    fs2_nxt = fs2_r;
    if (CTL_WE && sub_hit(wr_addr, PMX_SUB_AF)) begin
      af_nxt[port_idx] = CTL_WDATA; // RL14
    end
    // Select registers exist on port C only
    if (CTL_WE && port_idx == PMX_PORT_C && sub_hit(wr_addr, PMX_SUB_FS1)) begin
      fs1_nxt = CTL_WDATA; // RL14
    end
    if (CTL_WE && port_idx == PMX_PORT_C && sub_hit(wr_addr, PMX_SUB_FS2)) begin
      fs2_nxt = CTL_WDATA; // RL6
    end
    if (ADDR_WE && port_ok) begin
      addr_nxt[port_idx] = ADDR_WDATA; // RL14
    end
    rdata_nxt = 8'h00;
    if (port_ok && sub_hit(cur_addr, PMX_SUB_AF)) begin
      rdata_nxt = af_r[port_idx];
    end else if (port_idx == PMX_PORT_C && port_ok && sub_hit(cur_addr, PMX_SUB_FS1)) begin
      rdata_nxt = fs1_r;
    end else if (port_idx == PMX_PORT_C && port_ok && sub_hit(cur_addr, PMX_SUB_FS2)) begin
      rdata_nxt = fs2_r; // RL6
    end
  end

  // Pin routing; fs2_r is deliberately not read here
  always_comb begin
    c_drv_nxt = GPIO_C; // RL15
    d_drv_nxt = GPIO_D; // RL15
    e_drv_nxt = GPIO_E; // RL15
    pin_nxt   = PMX_PERIPH_IN_IDLE;
    ana_nxt   = '0;
    led_nxt   = 8'h00;
    // Port C: enable gates, select bit picks digital or analog/LED
    for (int i = 0; i < 8; i++) begin
      if (af_r[0][i] && fs1_r[i]) begin
        c_drv_nxt.oe[i]  = 1'h0; // RL7
        c_drv_nxt.out[i] = 1'h0;
        led_nxt[i]       = 1'h1; // RL4
      end else if (af_r[0][i]) begin
        c_drv_nxt.oe[i]  = 1'h0; // RL1
        c_drv_nxt.out[i] = 1'h0;
      end
    end
    if (af_r[0][0] && fs1_r[0]) begin
      ana_nxt.analog_channel_four       = 1'h1; // RL1
      ana_nxt.comparator0_positive_input = 1'h1;
    end
    if (af_r[0][1] && fs1_r[1]) begin
      ana_nxt.analog_channel_five       = 1'h1; // RL2
      ana_nxt.comparator0_negative_input = 1'h1;
    end
    if (af_r[0][2] && fs1_r[2]) begin
      ana_nxt.analog_channel_six = 1'h1; // RL3
    end
    if (af_r[0][PMX_C_SS] && !fs1_r[PMX_C_SS]) begin
      c_drv_nxt.out[PMX_C_SS] = PERIPH_OUT.spi_ss_out; // RL3
      c_drv_nxt.oe[PMX_C_SS]  = PERIPH_OUT.spi_ss_oe;
      pin_nxt.spi_ss_in       = c_s[PMX_C_SS];
    end
    if (af_r[0][PMX_C_CMP0] && !fs1_r[PMX_C_CMP0]) begin
      c_drv_nxt.out[PMX_C_CMP0] = PERIPH_OUT.comparator0_result_output;
      c_drv_nxt.oe[PMX_C_CMP0]  = 1'h1;
    end
    if (af_r[0][PMX_C_MOSI] && !fs1_r[PMX_C_MOSI]) begin
      c_drv_nxt.out[PMX_C_MOSI] = PERIPH_OUT.spi_mosi_out; // RL4
      c_drv_nxt.oe[PMX_C_MOSI]  = PERIPH_OUT.spi_mosi_oe;
      pin_nxt.spi_mosi_in       = c_s[PMX_C_MOSI];
    end
    if (af_r[0][PMX_C_SCK] && !fs1_r[PMX_C_SCK]) begin
      c_drv_nxt.out[PMX_C_SCK] = PERIPH_OUT.spi_sck_out; // RL4
      c_drv_nxt.oe[PMX_C_SCK]  = PERIPH_OUT.spi_sck_oe;
      pin_nxt.spi_sck_in       = c_s[PMX_C_SCK];
    end
    if (af_r[0][PMX_C_T2IO] && !fs1_r[PMX_C_T2IO]) begin
      c_drv_nxt.out[PMX_C_T2IO] = ~PERIPH_OUT.timer_two_output; // RL5
      c_drv_nxt.oe[PMX_C_T2IO]  = PERIPH_OUT.timer_two_oe;
      pin_nxt.timer_two_input   = c_s[PMX_C_T2IO];
    end
    if (af_r[0][PMX_C_T2] && !fs1_r[PMX_C_T2]) begin
      c_drv_nxt.out[PMX_C_T2] = PERIPH_OUT.timer_two_output; // RL5
      c_drv_nxt.oe[PMX_C_T2]  = 1'h1;
    end
    // Port D: one function per pin except PD3; pin 0 stays GPIO, reset is elsewhere
    if (af_r[1][1]) begin
      d_drv_nxt.oe[1]                   = 1'h0; // RL8
      ana_nxt.comparator1_negative_input = 1'h1;
    end
    if (af_r[1][2]) begin
      d_drv_nxt.oe[2]                   = 1'h0; // RL8
      ana_nxt.comparator1_positive_input = 1'h1;
    end
    if (af_r[1][PMX_D_CTS]) begin
      pin_nxt.uart_b_clear_to_send = d_s[PMX_D_CTS]; // RL10
      d_drv_nxt.out[PMX_D_CTS]     = PERIPH_OUT.comparator1_result_output; // RL10
      d_drv_nxt.oe[PMX_D_CTS]      = PERIPH_OUT.comparator1_oe;
    end
    if (af_r[1][PMX_D_RX]) begin
      pin_nxt.uart_b_receive = d_s[PMX_D_RX]; // RL11
      d_drv_nxt.oe[PMX_D_RX] = 1'h0;
    end
    if (af_r[1][PMX_D_TX]) begin
      d_drv_nxt.out[PMX_D_TX] = PERIPH_OUT.uart_b_transmit; // RL11
      d_drv_nxt.oe[PMX_D_TX]  = 1'h1;
    end
    if (af_r[1][PMX_D_DE]) begin
      d_drv_nxt.out[PMX_D_DE] = PERIPH_OUT.uart_b_driver_enable; // RL11
      d_drv_nxt.oe[PMX_D_DE]  = 1'h1;
    end
    if (af_r[1][PMX_D_CMP0]) begin
      d_drv_nxt.out[PMX_D_CMP0] = PERIPH_OUT.comparator0_result_output; // RL8
      d_drv_nxt.oe[PMX_D_CMP0]  = 1'h1;
    end
    // Port E: I2C is open drain, so it only ever drives low
    if (af_r[2][PMX_E_SCL]) begin
      e_drv_nxt.out[PMX_E_SCL] = 1'h0; // RL8
      e_drv_nxt.oe[PMX_E_SCL]  = PERIPH_OUT.i2c_scl_low;
      pin_nxt.i2c_scl_in       = e_s[PMX_E_SCL];
    end
    if (af_r[2][PMX_E_SDA]) begin
      e_drv_nxt.out[PMX_E_SDA] = 1'h0; // RL8
      e_drv_nxt.oe[PMX_E_SDA]  = PERIPH_OUT.i2c_sda_low;
      pin_nxt.i2c_sda_in       = e_s[PMX_E_SDA];
    end
    // Timer four: reserved in the small build, pin is released
    if (af_r[2][PMX_E_TIMER_FOUR_INPUT]) begin
      e_drv_nxt.oe[PMX_E_TIMER_FOUR_INPUT] = 1'h0;
      pin_nxt.timer_four_input = t4_ok & e_s[PMX_E_TIMER_FOUR_INPUT]; // RL9
    end
    for (int k = 0; k < 4; k++) begin
      if (af_r[2][PMX_E_T4CH+k]) begin
        e_drv_nxt.out[PMX_E_T4CH+k] = t4_ok & PERIPH_OUT.timer_four_ch_out[k]; // RL9
        e_drv_nxt.oe[PMX_E_T4CH+k]  = t4_ok & PERIPH_OUT.timer_four_ch_oe[k]; // RL9
        pin_nxt.timer_four_ch_in[k] = t4_ok & e_s[PMX_E_T4CH+k];
      end
    end
  end

  // All state registered; CE low holds everything
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      for (int p = 0; p < 3; p++) begin
        addr_r[p] <= PMX_ADDR_RST;
        af_r[p]   <= PMX_AF_RST;
      end
      fs1_r   <= PMX_AFS_RST;
      fs2_r   <= PMX_AFS_RST;
      rdata_r <= 8'h00;
      c_drv_r <= '0;
      d_drv_r <= '0;
      e_drv_r <= '0;
      pin_r   <= PMX_PERIPH_IN_IDLE;
      ana_r   <= '0;
      led_r   <= 8'h00;
    end else if (CE) begin
      addr_r  <= addr_nxt;
      af_r    <= af_nxt;
      fs1_r   <= fs1_nxt;
      fs2_r   <= fs2_nxt;
      rdata_r <= rdata_nxt;
      c_drv_r <= c_drv_nxt;
      d_drv_r <= d_drv_nxt;
      e_drv_r <= e_drv_nxt;
      pin_r   <= pin_nxt;
      ana_r   <= ana_nxt;
      led_r   <= led_nxt;
    end
  end

  assign PIN_C_DRV    = c_drv_r;
  assign PIN_D_DRV    = d_drv_r;
  assign PIN_E_DRV    = e_drv_r;
  assign PERIPH_IN    = pin_r;
  assign ANALOG_SEL   = ana_r;
  assign LED_DRIVE_EN = led_r;
  assign CTL_RDATA    = rdata_r;
  assign IRQ_REQ      = irq_w; // RL16

endmodule

// File: tb/pmx_port_mux_sva.sv
// Port-level assertions for the port C to E alternate-function mux
`timescale 1ns/1ps
module pmx_port_mux_sva
  import pmx_pkg::*;
(
  input wire logic                    CLK,
  input wire logic                    RSTN,
  input wire logic                    CE,
  input wire logic [7:0]              PIN_C_IN,
  input wire logic [7:0]              PIN_D_IN,
  input wire logic [7:0]              PIN_E_IN,
  input wire pmx_pin_drv_t            GPIO_D,
  input wire logic [1:0]              SUB_PORT_SEL,
  input wire logic [PMX_IRQ_PINS-1:0] IRQ_ANY_EDGE,
  input wire logic [PMX_IRQ_PINS-1:0] IRQ_RISING,
  input wire pmx_pin_drv_t            PIN_C_DRV,
  input wire pmx_pin_drv_t            PIN_D_DRV,
  input wire pmx_analog_t             ANALOG_SEL,
  input wire logic [7:0]              LED_DRIVE_EN,
  input wire logic [7:0]              CTL_RDATA,
  input wire logic [PMX_IRQ_PINS-1:0] IRQ_REQ
);
  logic [23:0] pins;
  logic [2:0]  ce_cnt_r;
  logic [2:0]  ce_cnt_nxt;
  assign pins = {PIN_E_IN, PIN_D_IN, PIN_C_IN};
  // Run length of active cycles; fixed delays only hold while nothing froze
  always_comb ce_cnt_nxt = !(CE && RSTN) ? 3'h0 : (ce_cnt_r == 3'h7) ? 3'h7 : ce_cnt_r + 3'h1;
  always_ff @(posedge CLK) ce_cnt_r <= ce_cnt_nxt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_irq_cause;
    ce_cnt_r > 3'h3 |-> (IRQ_REQ & ~($past(pins, 3) ^ $past(pins, 4))) == '0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without pin edge");
  property p_irq_any;
    ce_cnt_r > 3'h3 |->
      ($past(IRQ_ANY_EDGE) & ($past(pins, 3) ^ $past(pins, 4)) & ~IRQ_REQ) == '0;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("pin edge lost");
  property p_irq_rise;
    ce_cnt_r > 3'h3 |-> (IRQ_REQ & ~$past(IRQ_ANY_EDGE) & $past(IRQ_RISING)
      & ~($past(pins, 3) & ~$past(pins, 4))) == '0;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("rising request on other edge");
  property p_freeze;
    $past(RSTN) && !$past(CE) |-> $stable(IRQ_REQ) && $stable(PIN_C_DRV) && $stable(CTL_RDATA);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while held");
  property p_d0_gpio;
    ce_cnt_r > 3'h0 |-> PIN_D_DRV[8] == $past(GPIO_D[8]) && PIN_D_DRV[0] == $past(GPIO_D[0]);
  endproperty
  a_d0_gpio: assert property (p_d0_gpio) else $error("port D pin 0 not plain");
  property p_led_no_drive;
    LED_DRIVE_EN != 8'h00 |-> (LED_DRIVE_EN & PIN_C_DRV.oe) == 8'h00;
  endproperty
  a_led_no_drive: assert property (p_led_no_drive) else $error("LED pin driven");
  property p_an4;
    ANALOG_SEL.analog_channel_four |->
      ANALOG_SEL.comparator0_positive_input && LED_DRIVE_EN[0] && !PIN_C_DRV.oe[0];
  endproperty
  a_an4: assert property (p_an4) else $error("pin 0 analog set wrong");
  property p_an5;
    ANALOG_SEL.comparator0_negative_input == ANALOG_SEL.analog_channel_five
      && ANALOG_SEL.analog_channel_five == LED_DRIVE_EN[1];
  endproperty
  a_an5: assert property (p_an5) else $error("pin 1 analog set wrong");
  property p_an6;
    ANALOG_SEL.analog_channel_six == LED_DRIVE_EN[2];
  endproperty
  a_an6: assert property (p_an6) else $error("pin 2 analog set wrong");
  property p_sel_none;
    ce_cnt_r > 3'h0 && $past(SUB_PORT_SEL) == 2'h3 |-> CTL_RDATA == 8'h00;
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("unselected port read back");
  c_irq: cover property (IRQ_REQ != '0);
  c_led: cover property (LED_DRIVE_EN != 8'h00);
  c_an: cover property (ANALOG_SEL.analog_channel_four);
endmodule

// File: tb/pmx_far_side.sv
// Far-side model: peripherals and the pins that feed the mux
`timescale 1ns/1ps
module pmx_far_side
  import pmx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       run,
  output pmx_periph_out_t periph_out,
  output logic [23:0]     pins
);
  integer      seed = 32'h9145da43;
  logic [31:0] r;
  initial periph_out = '0;
  initial pins = 24'h000000;
  // Peripherals move every cycle; pins stand still while run is low
  always @(posedge clk) begin
    r = $random(seed);
    periph_out <= r[$bits(pmx_periph_out_t)-1:0];
    if (run) pins <= 24'($random(seed));
  end
endmodule

// File: tb/pmx_port_mux_tb.sv
// Self-checking bench with reference model for the port C to E mux
`timescale 1ns/1ps
module pmx_port_mux_tb
  import pmx_pkg::*;
;
  localparam int N_CYC = 3000;
  logic            clk = 1'h0;
  logic            rstn = 1'h0;
  logic            ce = 1'h1;
  logic            run = 1'h0;
  logic            live = 1'h0;
  logic            addr_we = 1'h0;
  logic            ctl_we = 1'h0;
  logic [1:0]      sel = 2'h0;
  logic [7:0]      addr_wdata = 8'h00;
  logic [7:0]      ctl_wdata = 8'h00;
  logic [23:0]     any = 24'h000000;
  logic [23:0]     ris = 24'h000000;
  pmx_pin_drv_t    gpio_c = '0;
  pmx_pin_drv_t    gpio_d = '0;
  pmx_pin_drv_t    gpio_e = '0;
  logic [23:0]     pins;
  pmx_periph_out_t pout;
  pmx_pin_drv_t    c_drv, d_drv, e_drv, es_drv, e_c, e_d, e_e, e_es;
  pmx_periph_in_t  p_in, ps_in, e_pi, e_pis;
  pmx_analog_t     an, e_an;
  logic [7:0]      led, rdat, e_led, e_rd, m_fs1, m_fs2;
  logic [7:0]      m_addr [3];
  logic [7:0]      m_af [3];
  logic [7:0]      subs [8] = '{8'h00, 8'h02, 8'h07, 8'h08, 8'h02, 8'h07, 8'h01, 8'h09};
  logic [23:0]     irq, e_irq, s1, s2, s3;
  int              failures = 0;
  int              n_compared = 0;
  integer          seed = 32'h9145da43;
  logic [31:0]     r;

  pmx_port_mux i_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .PIN_C_IN(pins[7:0]),
    .PIN_D_IN(pins[15:8]), .PIN_E_IN(pins[23:16]), .GPIO_C(gpio_c), .GPIO_D(gpio_d),
    .GPIO_E(gpio_e), .PERIPH_OUT(pout), .SUB_PORT_SEL(sel), .ADDR_WE(addr_we),
    .ADDR_WDATA(addr_wdata), .CTL_WE(ctl_we), .CTL_WDATA(ctl_wdata), .IRQ_ANY_EDGE(any),
    .IRQ_RISING(ris), .PIN_C_DRV(c_drv), .PIN_D_DRV(d_drv), .PIN_E_DRV(e_drv),
    .PERIPH_IN(p_in), .ANALOG_SEL(an), .LED_DRIVE_EN(led), .CTL_RDATA(rdat), .IRQ_REQ(irq));
  // Smaller package build sees the same stimulus
  pmx_port_mux #(.LARGE_PKG(1'h0)) i_dut_small (.CLK(clk), .RSTN(rstn), .CE(ce),
    .PIN_C_IN(pins[7:0]), .PIN_D_IN(pins[15:8]), .PIN_E_IN(pins[23:16]), .GPIO_C(gpio_c),
    .GPIO_D(gpio_d), .GPIO_E(gpio_e), .PERIPH_OUT(pout), .SUB_PORT_SEL(sel),
    .ADDR_WE(addr_we), .ADDR_WDATA(addr_wdata), .CTL_WE(ctl_we), .CTL_WDATA(ctl_wdata),
    .IRQ_ANY_EDGE(any), .IRQ_RISING(ris), .PIN_C_DRV(), .PIN_D_DRV(), .PIN_E_DRV(es_drv),
    .PERIPH_IN(ps_in), .ANALOG_SEL(), .LED_DRIVE_EN(), .CTL_RDATA(), .IRQ_REQ());
  pmx_far_side i_far (.clk(clk), .run(run), .periph_out(pout), .pins(pins));

  always #50 clk = ~clk;

  // Alternate value where enabled, plain GPIO elsewhere
  function automatic pmx_pin_drv_t mix(logic [7:0] af, pmx_pin_drv_t v, pmx_pin_drv_t g);
    return {(af & v.out) | (~af & g.out), (af & v.oe) | (~af & g.oe)};
  endfunction
  function automatic pmx_pin_drv_t fc(logic [7:0] fs);
    pmx_periph_out_t p;
    p = pout;
    return mix(m_af[0], {p.timer_two_output, ~p.timer_two_output, p.spi_sck_out,
      p.spi_mosi_out, p.comparator0_result_output, p.spi_ss_out, 2'h0, 1'h1,
      p.timer_two_oe, p.spi_sck_oe, p.spi_mosi_oe, 1'h1, p.spi_ss_oe, 2'h0} & {2{~fs}}, gpio_c);
  endfunction
  function automatic pmx_pin_drv_t fd();
    pmx_periph_out_t p;
    p = pout;
    return mix(m_af[1], {p.comparator0_result_output, p.uart_b_driver_enable,
      p.uart_b_transmit, 1'h0, p.comparator1_result_output, 2'h0, gpio_d.out[0], 3'h7,
      1'h0, p.comparator1_oe, 2'h0, gpio_d.oe[0]}, gpio_d);
  endfunction
  // Timer four pins fall back to released in the small build
  function automatic pmx_pin_drv_t fe(logic lg);
    pmx_periph_out_t p;
    p = pout;
    return mix(m_af[2], {gpio_e.out[7], p.timer_four_ch_out & {4{lg}}, 3'h0, gpio_e.oe[7],
      p.timer_four_ch_oe & {4{lg}}, p.i2c_sda_low, p.i2c_scl_low, 1'h0}, gpio_e);
  endfunction
  function automatic pmx_periph_in_t fpi(logic lg);
    logic [7:0] c;
    c = m_af[0] & ~m_fs1;
    return {c[2] ? s2[2] : 1'h1, c[4] & s2[4], c[5] & s2[5], c[6] & s2[6],
      m_af[1][3] ? s2[11] : 1'h1, m_af[1][4] ? s2[12] : 1'h1, m_af[2][1] ? s2[17] : 1'h1,
      m_af[2][2] ? s2[18] : 1'h1, m_af[2][0] & lg & s2[16], m_af[2][6:3] & {4{lg}} & s2[22:19]};
  endfunction
  function automatic logic [7:0] rd_exp();
    if (sel == 2'h3) return 8'h00;
    if (m_addr[sel] == PMX_SUB_AF) return m_af[sel];
    if (sel == PMX_PORT_C && m_addr[sel] == PMX_SUB_FS1) return m_fs1;
    if (sel == PMX_PORT_C && m_addr[sel] == PMX_SUB_FS2) return m_fs2;
    return 8'h00;
  endfunction

  // Reference model, one edge per active cycle like the design
  always @(posedge clk) begin
    if (!rstn) begin
      m_addr <= '{default: PMX_ADDR_RST};
      m_af <= '{default: PMX_AF_RST};
      m_fs1 <= PMX_AFS_RST;
      m_fs2 <= PMX_AFS_RST;
      {s1, s2, s3, e_irq, e_led, e_rd} <= '0;
      {e_c, e_d, e_e, e_es, e_an} <= '0;
      e_pi <= PMX_PERIPH_IN_IDLE;
      e_pis <= PMX_PERIPH_IN_IDLE;
    end else if (ce) begin
      {s1, s2, s3} <= {pins, s1, s2};
      e_irq <= (any & (s2 ^ s3)) | (~any & ris & s2 & ~s3) | (~any & ~ris & ~s2 & s3);
      {e_c, e_d, e_e, e_es} <= {fc(m_fs1), fd(), fe(1'h1), fe(1'h0)};
      {e_pi, e_pis} <= {fpi(1'h1), fpi(1'h0)};
      e_led <= m_af[0] & m_fs1;
      e_an <= {m_af[0][0] & m_fs1[0], m_af[0][1] & m_fs1[1], m_af[0][2] & m_fs1[2],
        m_af[0][0] & m_fs1[0], m_af[0][1] & m_fs1[1], m_af[1][1], m_af[1][2]};
      e_rd <= rd_exp();
      if (addr_we && sel != 2'h3) m_addr[sel] <= addr_wdata;
      if (ctl_we && sel != 2'h3 && m_addr[sel] == PMX_SUB_AF) m_af[sel] <= ctl_wdata;
      if (ctl_we && sel == PMX_PORT_C && m_addr[0] == PMX_SUB_FS1) m_fs1 <= ctl_wdata;
      if (ctl_we && sel == PMX_PORT_C && m_addr[0] == PMX_SUB_FS2) m_fs2 <= ctl_wdata;
    end
  end

  task automatic chk_vec(logic [31:0] got, logic [31:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask
  // Released pins carry no meaningful level, so output levels compare only on driven bits
  task automatic chk_drv(pmx_pin_drv_t got, pmx_pin_drv_t exp, string what);
    chk_vec({got.oe, got.out & exp.oe}, {exp.oe, exp.out & exp.oe}, what);
  endtask
  // All results checked mid-cycle, once both sides have settled
  always @(negedge clk) begin
    if (live) begin
      chk_drv(c_drv, e_c, "port C drive");
      chk_drv(d_drv, e_d, "port D drive");
      chk_drv(e_drv, e_e, "port E drive");
      chk_drv(es_drv, e_es, "small port E drive");
      chk_vec(p_in, e_pi, "peripheral input");
      chk_vec(ps_in, e_pis, "small peripheral input");
      chk_vec(led, e_led, "LED enable");
      chk_vec(an, e_an, "analog select");
      chk_vec(rdat, e_rd, "readback");
      chk_vec(irq, e_irq, "pin request");
    end
  end

  task automatic end_of_test();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard at three times the planned run
  initial begin
    #(N_CYC * 300);
    failures++;
    end_of_test();
  end
  // Reset, then random config, GPIO and hold traffic; modes change with pins still
  initial begin
    repeat (2) @(posedge clk);
    live <= 1'h1;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    for (int k = 0; k < N_CYC; k++) begin
      @(posedge clk);
      r = $random(seed);
      ce <= r[2:0] != 3'h0;
      sel <= r[4:3];
      addr_we <= r[6:5] == 2'h0;
      ctl_we <= r[8:7] != 2'h0;
      addr_wdata <= subs[r[11:9]];
      ctl_wdata <= r[31:24];
      run <= (k % 200) > 5;
      rstn <= k != 1500; // One-cycle reset mid-run, CE random
      if (k % 200 == 4) any <= 24'($random(seed));
      if (k % 200 == 4) ris <= 24'($random(seed));
      r = $random(seed);
      gpio_c <= r[15:0];
      gpio_d <= r[31:16];
      r = $random(seed);
      gpio_e <= r[15:0];
    end
    end_of_test();
  end
endmodule

bind pmx_port_mux pmx_port_mux_sva i_sva (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .PIN_C_IN(PIN_C_IN), .PIN_D_IN(PIN_D_IN), .PIN_E_IN(PIN_E_IN), .GPIO_D(GPIO_D),
  .SUB_PORT_SEL(SUB_PORT_SEL), .IRQ_ANY_EDGE(IRQ_ANY_EDGE), .IRQ_RISING(IRQ_RISING),
  .PIN_C_DRV(PIN_C_DRV), .PIN_D_DRV(PIN_D_DRV), .ANALOG_SEL(ANALOG_SEL),
  .LED_DRIVE_EN(LED_DRIVE_EN), .CTL_RDATA(CTL_RDATA), .IRQ_REQ(IRQ_REQ));
